// *** design/frac_gen.sv ***
// Purpose: divides the integer baud tick by M + N/2048
// Assumes: int_tick is one cycle wide, never two in a row needed
// Notes: bypass passes int_tick straight through, one cycle late
`timescale 1ns/1ps
module frac_gen import uart_ext_pkg::*; (
    input wire logic clk,   // core clock
    input wire logic rst_n, // async reset, low
    input wire logic ce,    // clock enable
    frac_if.gen fi          // settings and ticks
);
    logic [13:0] acc_q, acc_d, lim, sum;
    logic tick_q, tick_d;
    logic [2:0] m_eff;

    always_comb begin
        m_eff = (fi.m == 2'h0) ? FRAC_M_ZERO : {1'b0, fi.m};
        lim = {m_eff, 11'h000} + {3'h0, fi.n};
        sum = acc_q + FRAC_UNIT;
        acc_d = '0;
        tick_d = fi.int_tick;
        if (fi.en) begin
            tick_d = 1'b0;
            acc_d = acc_q;
            if (fi.int_tick) begin
                if (sum >= lim) begin
                    acc_d = sum - lim;
                    tick_d = 1'b1;
                end else begin
                    acc_d = sum;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign fi.tick = tick_q;

    AST_FRAC_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !fi.en) |=> (tick_q == $past(fi.int_tick)))
        else $error("integer tick not passed through");
endmodule

// *** design/frac_if.sv ***
// Purpose: link between register logic and fractional baud generator
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface frac_if;
    logic en;
    logic [1:0] m;
    logic [10:0] n;
    logic int_tick;
    logic tick;
    modport gen (input en, m, n, int_tick, output tick);
    modport ctl (output en, m, n, int_tick, input tick);
endinterface

// *** design/modem_line.sv ***
// Purpose: one modem status line with loopback and change flag
// Assumes: pin is active low and asynchronous
// Notes: flag bits already reported are cleared, later events kept
`timescale 1ns/1ps
module modem_line #(
    parameter bit FALL_ONLY = 1'b0
) (
    input wire logic clk,      // core clock
    input wire logic rst_n,    // async reset, low
    input wire logic ce,       // clock enable
    input wire logic pin_n,    // modem pin
    input wire logic loop_en,  // loopback on
    input wire logic loop_lvl, // looped level
    input wire logic clr,      // clear reported flag
    output logic lvl,          // line level, true sense
    output logic flag          // change flag
);
    logic s1_q, s2_q, lvl_q, lvl_d, flag_q, flag_d, chg;

    always_comb begin
        lvl_d = loop_en ? loop_lvl : ~s2_q;
        chg = FALL_ONLY ? (lvl_q & ~lvl_d) : (lvl_q ^ lvl_d);
        flag_d = (flag_q & ~clr) | chg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            lvl_q <= 1'b0;
            flag_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin_n;
            s2_q <= s1_q;
            lvl_q <= lvl_d;
            flag_q <= flag_d;
        end
    end

    assign lvl = lvl_q;
    assign flag = flag_q;

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && chg) |=> flag_q)
        else $error("line change not flagged");
    AST_FLAG_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && clr && !chg) |=> !flag_q)
        else $error("flag not cleared by read");
endmodule

// *** design/uart_ext_pkg.sv ***
// Purpose: shared constants of the modem, baud and network extension
// Assumes: word-indexed register map on a 32-bit bus
// Notes: field positions and codes used by more than one file
package uart_ext_pkg;
    // ==========================================
    // Register word indices
    localparam int AW = 3;
    localparam logic [AW-1:0] ADR_MODEM_CONTROL = 3'h0;
    localparam logic [AW-1:0] ADR_MODEM_STATUS = 3'h1;
    localparam logic [AW-1:0] ADR_FRAC_DIVIDER = 3'h2;
    localparam logic [AW-1:0] ADR_SCRATCH_STORE = 3'h3;
    localparam logic [AW-1:0] ADR_NODE_ADDRESS = 3'h4;
    localparam logic [AW-1:0] ADR_NETWORK_ENABLE = 3'h5;
    localparam logic [AW-1:0] ADR_NET_IRQ_IDENT = 3'h6;
    // ==========================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    // ==========================================
    // Modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_AUX_OUTPUT_ONE = 2;
    localparam int MC_AUX_OUTPUT_TWO = 3;
    localparam int MC_LOOP = 4;
    localparam logic [7:0] MC_MASK = 8'h1F;
    // ==========================================
    // Modem status: flag i at bit i, level i at bit LVL_BASE+i
    // Line order: 0 CTS, 1 DSR, 2 RI, 3 DCD
    localparam int N_LINES = 4;
    localparam int LVL_BASE = 4;
    localparam int LN_RI = 2;
    // ==========================================
    // Fractional divider fields
    localparam int FD_EN = 15;
    localparam int FD_M_LO = 11;
    localparam int FD_N_HI = 10;
    localparam logic [15:0] FD_MASK = 16'h9FFF;
    localparam logic [2:0] FRAC_M_ZERO = 3'h4;
    localparam logic [13:0] FRAC_UNIT = 14'h0800;
    // ==========================================
    // Network enable fields
    localparam int NE_ADDRESS_SEND_SELECT = 0;
    localparam int NE_ADDRESS_IRQ_POLARITY = 1;
    localparam int NE_TX_DRIVER_ENABLE = 2;
    localparam int NE_NINE_BIT_DATA_SELECT = 3;
    localparam int NE_NETWORK_IRQ_ENABLE = 4;
    localparam int NE_NINE_BIT_RX_ENABLE = 5;
    localparam int NE_NINE_BIT_TX_ENABLE = 6;
    localparam int NE_NETWORK_MODE_ENABLE = 7;
    // ==========================================
    // Network interrupt identification, bits 3-1 code, bit 0 none
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_MATCH = 4'hC;
    localparam logic [3:0] IID_ADDR_SENT = 4'hA;
endpackage

// *** design/uart_modem_fracbaud_netaddr.sv ***
// Purpose: modem, fractional baud and network extension of a UART
// Assumes: base UART on the same clock supplies tick and frame strobes
// Notes: Avalon-MM slave, one wait cycle per access
//
// How it works
// - Loopback holds transmit pin high
// - Loopback feeds modem outputs to status inputs
// - RTS pin is inverse of its bit
// - DTR pin is inverse of its bit
// - Carrier change flag, cleared by status read
// - Ring trailing edge flag, cleared by read
// - Set ready change flag, cleared by read
// - Clear to send change flag, cleared by read
// - Bit 15 selects fractional baud generator
// - M field 12-11, zero means 4
// - Network mode only while enable bit 7
// - Network mode: no parity, marker instead
// - Scratch bit zero picks outgoing marker
// - Received address match sets network interrupt
// - Eight bit address, up to 256 nodes
// - Network registers act only in network mode
// - Bit 6 enables nine bit transmit
// - Bit 5 enables nine bit receive
// - Bit 3 selects nine bit data
// - Bit 2 drives pin, else three-state
// - Bit 4 enables network interrupts
// - Bit 0 sends slave address marker
// - Identification codes 110 match, 101 sent
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module uart_modem_fracbaud_netaddr import uart_ext_pkg::*; (
    input wire logic CLOCK,               // core clock
    input wire logic RSTN,                // async reset, low
    input wire logic CE,                  // clock enable
    input wire logic [AW-1:0] AVS_ADDRESS, // word index
    input wire logic AVS_READ,            // read request
    input wire logic AVS_WRITE,           // write request
    input wire logic [31:0] AVS_WRITEDATA, // write data
    input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
    output logic [31:0] AVS_READDATA,     // read data
    output logic AVS_WAITREQUEST,         // stall
    input wire logic CTS_N,               // clear to send pin
    input wire logic DSR_N,               // data set ready pin
    input wire logic RING_INPUT_INVERTED, // ring pin, low active
    input wire logic DCD_N,               // carrier detect pin
    output logic RTS_N,                   // request to send pin
    output logic DTR_N,                   // terminal ready pin
    output logic AUX_OUTPUT_ONE_N,        // aux output one pin
    output logic AUX_OUTPUT_TWO_N,        // aux output two pin
    input wire logic TX_SERIAL,           // frame from transmitter
    output logic SERIAL_TX_PIN_O,         // transmit pin level
    output logic SERIAL_TX_PIN_OE,        // transmit pin enable
    input wire logic INT_BAUD_TICK,       // integer divider tick
    output logic BAUD_TICK,               // tick to base UART
    input wire logic RX_WORD_VALID,       // word received
    input wire logic RX_MARKER,           // received marker bit
    input wire logic [7:0] RX_WORD,       // received byte
    input wire logic RX_DATA_READ,        // software read rx data
    input wire logic TX_EMPTY,            // transmit buffer empty
    input wire logic TX_DATA_WRITE,       // software wrote tx data
    input wire logic IID0_READ,           // base ident read
    output logic TX_MARKER,               // marker to transmitter
    output logic PARITY_CHECK_EN,         // parity check allowed
    output logic NINE_BIT_TX_EN,          // nine bit transmit
    output logic NINE_BIT_RX_EN,          // nine bit receive
    output logic NINE_BIT_DATA_SEL,       // nine bit data word
    output logic LOOPBACK_ON,             // loopback to base UART
    output logic NET_IRQ                  // network interrupt
);
    // ==========================================
    // Bus and register state
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] mctrl_q, mctrl_d;
    logic [15:0] fdiv_q, fdiv_d;
    logic [7:0] scr_q, scr_d;
    logic [7:0] adr_q, adr_d;
    logic [7:0] nen_q, nen_d;
    logic req, take, wr, rd;
    logic [7:0] be_lo;
    logic [N_LINES-1:0] lvl, flag, loop_lvl, ln_clr;
    logic [N_LINES-1:0] pin_n;
    logic [3:0] iid;
    logic net;

    assign req = (AVS_READ | AVS_WRITE) & CE;
    assign take = req & ~wait_q;
    assign wr = take & AVS_WRITE;
    assign rd = take & AVS_READ;
    assign be_lo = AVS_WRITEDATA[7:0];
    assign net = nen_q[NE_NETWORK_MODE_ENABLE];

    // ==========================================
    // Register file and bus answer
    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        mctrl_d = mctrl_q;
        fdiv_d = fdiv_q;
        scr_d = scr_q;
        adr_d = adr_q;
        nen_d = nen_q;
        if (req && wait_q) begin
            // Data captured a cycle before the take so it is stable
            wait_d = 1'b0;
            rdata_d = '0;
            case (AVS_ADDRESS)
                ADR_MODEM_CONTROL: rdata_d[7:0] = mctrl_q;
                ADR_MODEM_STATUS: rdata_d[7:0] = {lvl, flag};
                ADR_FRAC_DIVIDER: rdata_d[15:0] = fdiv_q;
                ADR_SCRATCH_STORE: rdata_d[7:0] = scr_q;
                ADR_NODE_ADDRESS: rdata_d[7:0] = adr_q;
                ADR_NETWORK_ENABLE: rdata_d[7:0] = nen_q;
                ADR_NET_IRQ_IDENT: rdata_d[3:0] = iid;
                default: rdata_d = '0;
            endcase
        end
        if (wr && AVS_BYTEENABLE[0]) begin
            case (AVS_ADDRESS)
                ADR_MODEM_CONTROL: mctrl_d = be_lo & MC_MASK;
                ADR_FRAC_DIVIDER: fdiv_d[7:0] = be_lo;
                ADR_SCRATCH_STORE: scr_d = be_lo;
                ADR_NODE_ADDRESS: adr_d = be_lo;
                ADR_NETWORK_ENABLE: nen_d = be_lo;
                default: ;
            endcase
        end
        if (wr && AVS_BYTEENABLE[1] && AVS_ADDRESS == ADR_FRAC_DIVIDER) begin
            fdiv_d[15:8] = AVS_WRITEDATA[15:8] & FD_MASK[15:8];
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            mctrl_q <= RST_BYTE;
            fdiv_q <= RST_HALF;
            scr_q <= RST_BYTE;
            adr_q <= RST_BYTE;
            nen_q <= RST_BYTE;
        end else if (CE) begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            mctrl_q <= mctrl_d;
            fdiv_q <= fdiv_d;
            scr_q <= scr_d;
            adr_q <= adr_d;
            nen_q <= nen_d;
        end
    end

    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;

    // ==========================================
    // Modem status lines
    // loopback routing
    assign loop_lvl = {mctrl_q[MC_AUX_OUTPUT_TWO], mctrl_q[MC_AUX_OUTPUT_ONE],
                       mctrl_q[MC_DTR], mctrl_q[MC_RTS]};
    assign pin_n = {DCD_N, RING_INPUT_INVERTED, DSR_N, CTS_N};
    // Only flags shown in the answer clear, so no event is lost
    assign ln_clr = (rd && AVS_ADDRESS == ADR_MODEM_STATUS) ?
                    rdata_q[N_LINES-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < N_LINES; gi++) begin : g_line
            modem_line #(
                .FALL_ONLY(gi == LN_RI)
            ) u_line (
                .clk(CLOCK),
                .rst_n(RSTN),
                .ce(CE),
                .pin_n(pin_n[gi]),
                .loop_en(mctrl_q[MC_LOOP]),
                .loop_lvl(loop_lvl[gi]),
                .clr(ln_clr[gi]),
                .lvl(lvl[gi]),
                .flag(flag[gi])
            );
        end
    endgenerate

    // ==========================================
    // Baud generator
    frac_if fb ();
    assign fb.en = fdiv_q[FD_EN];
    assign fb.m = fdiv_q[FD_M_LO+1:FD_M_LO];
    assign fb.n = fdiv_q[FD_N_HI:0];
    assign fb.int_tick = INT_BAUD_TICK;

    frac_gen u_frac (
        .clk(CLOCK),
        .rst_n(RSTN),
        .ce(CE),
        .fi(fb.gen)
    );
    assign BAUD_TICK = fb.tick;

    // ==========================================
    // Network events
    logic match_q, match_d, sent_q, sent_d;
    logic addr_tx_q, addr_tx_d, empty_q;
    logic match_ev, sent_ev, marker;

    assign marker = net & (scr_q[0] | nen_q[NE_ADDRESS_SEND_SELECT]);
    assign match_ev = RX_WORD_VALID & RX_MARKER & net & nen_q[NE_NINE_BIT_RX_ENABLE]
                      & (RX_WORD == adr_q);
    assign sent_ev = TX_EMPTY & ~empty_q & addr_tx_q & net;

    always_comb begin
        addr_tx_d = TX_DATA_WRITE ? marker : addr_tx_q;
        match_d = (match_q & ~RX_DATA_READ) | match_ev;
        sent_d = (sent_q & ~(TX_DATA_WRITE | IID0_READ)) | sent_ev;
        if (match_q) begin
            iid = IID_MATCH;
        end else if (sent_q) begin
            iid = IID_ADDR_SENT;
        end else begin
            iid = IID_NONE;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            match_q <= 1'b0;
            sent_q <= 1'b0;
            addr_tx_q <= 1'b0;
            empty_q <= 1'b0;
        end else if (CE) begin
            match_q <= match_d;
            sent_q <= sent_d;
            addr_tx_q <= addr_tx_d;
            empty_q <= TX_EMPTY;
        end
    end

    // ==========================================
    // Registered pins and controls
    logic [12:0] out_q, out_d;

    always_comb begin
        out_d[0] = ~mctrl_q[MC_RTS];
        out_d[1] = ~mctrl_q[MC_DTR];
        out_d[2] = ~mctrl_q[MC_AUX_OUTPUT_ONE];
        out_d[3] = ~mctrl_q[MC_AUX_OUTPUT_TWO];
        out_d[4] = mctrl_q[MC_LOOP] | TX_SERIAL;
        out_d[5] = mctrl_q[MC_LOOP] | ~net | nen_q[NE_TX_DRIVER_ENABLE];
        out_d[6] = marker;
        out_d[7] = ~net;
        out_d[8] = net & nen_q[NE_NINE_BIT_TX_ENABLE];
        out_d[9] = net & nen_q[NE_NINE_BIT_RX_ENABLE];
        out_d[10] = net & nen_q[NE_NINE_BIT_DATA_SELECT];
        out_d[11] = mctrl_q[MC_LOOP];
        out_d[12] = net & nen_q[NE_NETWORK_IRQ_ENABLE] & (match_d | sent_d);
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            // Marker bit low in reset, same as zero registers give
            out_q <= 13'h00BF;
        end else if (CE) begin
            out_q <= out_d;
        end
    end

    assign RTS_N = out_q[0];
    assign DTR_N = out_q[1];
    assign AUX_OUTPUT_ONE_N = out_q[2];
    assign AUX_OUTPUT_TWO_N = out_q[3];
    assign SERIAL_TX_PIN_O = out_q[4];
    assign SERIAL_TX_PIN_OE = out_q[5];
    assign TX_MARKER = out_q[6];
    assign PARITY_CHECK_EN = out_q[7];
    assign NINE_BIT_TX_EN = out_q[8];
    assign NINE_BIT_RX_EN = out_q[9];
    assign NINE_BIT_DATA_SEL = out_q[10];
    assign LOOPBACK_ON = out_q[11];
    assign NET_IRQ = out_q[12];

    // ==========================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    sequence s_req;
        req && wait_q;
    endsequence
    sequence s_iid_req;
        s_req ##0 AVS_READ && AVS_ADDRESS == ADR_NET_IRQ_IDENT;
    endsequence

    AST_BUS_ONE_WAIT: assert property (s_req |=> !AVS_WAITREQUEST)
        else $error("no answer one cycle after request");
    AST_LOOP_TX_HIGH: assert property (
        (CE && mctrl_q[MC_LOOP]) |=> SERIAL_TX_PIN_O)
        else $error("transmit pin not high in loopback");
    AST_RTS_LEVEL: assert property (
        CE |=> (RTS_N == !$past(mctrl_q[MC_RTS])))
        else $error("RTS pin disagrees with bit");
    AST_DTR_LEVEL: assert property (
        CE |=> (DTR_N == !$past(mctrl_q[MC_DTR])))
        else $error("DTR pin disagrees with bit");
    AST_NET_GATE: assert property (
        (CE && !net) |=> (!NINE_BIT_TX_EN && !NINE_BIT_RX_EN
                          && PARITY_CHECK_EN && !TX_MARKER))
        else $error("network controls active outside network mode");
    AST_TX_TRISTATE: assert property (
        (CE && net && !nen_q[NE_TX_DRIVER_ENABLE] && !mctrl_q[MC_LOOP])
        |=> !SERIAL_TX_PIN_OE)
        else $error("transmit pin driven while disabled");
    AST_MARKER_ADDR: assert property (
        (CE && net && scr_q[0]) |=> TX_MARKER)
        else $error("address marker not sent");
    AST_MATCH_SET: assert property (
        (CE && match_ev) |=> match_q)
        else $error("address match not recorded");
    AST_IID_MATCH: assert property (
        (s_iid_req ##0 match_q) |=> (AVS_READDATA[3:0] == IID_MATCH))
        else $error("wrong code for address match");
    AST_IRQ_ENABLE: assert property (
        (CE && !nen_q[NE_NETWORK_IRQ_ENABLE]) |=> !NET_IRQ)
        else $error("network interrupt while disabled");
endmodule

// *** sim/modem_peer.sv ***
// Purpose: far-end modem that drives the four status pins
// Assumes: the bench names wanted levels in true sense
// Notes: pins are active low; LAG models a slow modem
`timescale 1ns/1ps
module modem_peer #(
    parameter int LAG = 2
) (
    input wire logic clk,        // core clock
    input wire logic [3:0] want, // levels: 0 CTS 1 DSR 2 RI 3 DCD
    output logic cts_n,          // clear to send pin
    output logic dsr_n,          // data set ready pin
    output logic ri_n,           // ring pin
    output logic dcd_n           // carrier pin
);
    // ==========================================
    // Lagged pin drive
    logic [3:0] hist [LAG];
    initial begin
        foreach (hist[i]) hist[i] = 4'h0;
    end
    always @(posedge clk) begin
        hist[0] <= want;
        for (int i = 1; i < LAG; i++) hist[i] <= hist[i-1];
    end
    assign {dcd_n, ri_n, dsr_n, cts_n} = ~hist[LAG-1];
endmodule

// *** sim/uart_modem_fracbaud_netaddr_test.sv ***
// Purpose: self-checking bench of the modem, baud and network extension
// Assumes: Avalon-MM answers after one wait cycle, but no count is relied on
// Notes: read results are checked by a monitor against a queue of notes
`timescale 1ns/1ps
module uart_modem_fracbaud_netaddr_test;
    import uart_ext_pkg::*;
    logic clock = 0, rstn = 0, rd = 0, wr = 0, tx_serial = 0, int_tick = 0;
    logic rx_valid = 0, rx_marker = 0, rx_read = 0, tx_empty = 1, tx_write = 0, iid_read = 0;
    logic [AW-1:0] addr = 3'h0;
    logic [31:0] wdata = 32'h0, readdata, w1, w2;
    logic [3:0] be = 4'hF, want = 4'h0;
    logic [7:0] rx_word = 8'h00, node;
    logic waitreq, rts_n, dtr_n, aux1_n, aux2_n, pin_o, pin_oe, baud_tick, tx_marker;
    logic parity_en, nbt, nbr, nbd, loop_on, net_irq, cts_n, dsr_n, ri_n, dcd_n;
    logic [31:0] exp_q [$];
    int fails = 0, checks_done = 0, seed = 32'h6AA8, tick_cnt = 0;
    always #20 clock = ~clock;
    modem_peer #(.LAG(2)) peer_u (.clk(clock), .want(want), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .dcd_n(dcd_n));
    uart_modem_fracbaud_netaddr dut_u (.CLOCK(clock), .RSTN(rstn), .CE(1'b1),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(be), .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitreq),
        .CTS_N(cts_n), .DSR_N(dsr_n), .RING_INPUT_INVERTED(ri_n), .DCD_N(dcd_n),
        .RTS_N(rts_n), .DTR_N(dtr_n), .AUX_OUTPUT_ONE_N(aux1_n), .AUX_OUTPUT_TWO_N(aux2_n),
        .TX_SERIAL(tx_serial), .SERIAL_TX_PIN_O(pin_o), .SERIAL_TX_PIN_OE(pin_oe),
        .INT_BAUD_TICK(int_tick), .BAUD_TICK(baud_tick), .RX_WORD_VALID(rx_valid),
        .RX_MARKER(rx_marker), .RX_WORD(rx_word), .RX_DATA_READ(rx_read),
        .TX_EMPTY(tx_empty), .TX_DATA_WRITE(tx_write), .IID0_READ(iid_read),
        .TX_MARKER(tx_marker), .PARITY_CHECK_EN(parity_en), .NINE_BIT_TX_EN(nbt),
        .NINE_BIT_RX_EN(nbr), .NINE_BIT_DATA_SEL(nbd), .LOOPBACK_ON(loop_on),
        .NET_IRQ(net_irq));
    // ==========================================
    // Checking and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read results land when waitrequest is seen low
    always @(posedge clock) begin
        if (rd === 1'b1 && waitreq === 1'b0) begin
            if (exp_q.size() == 0) check(readdata, 32'hDEAD);
            else check(readdata, exp_q.pop_front());
        end
    end
    always @(posedge clock) if (baud_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        print_verdict();
    end
    // ==========================================
    // Bus and pulse tasks
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clock);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        be <= b;
        do begin
            @(posedge clock);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) check(32'h1, 32'h0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
        // Pins are registered from the new value one edge later
        @(posedge clock);
    endtask
    task automatic rreg(input logic [2:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic rx(input logic [7:0] w);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_marker <= 1'b1;
        rx_word <= w;
        @(posedge clock);
        rx_valid <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic ticks(input int n, input int e);
        tick_cnt = 0;
        repeat (n) begin
            @(posedge clock);
            int_tick <= 1'b1;
            @(posedge clock);
            int_tick <= 1'b0;
            repeat (2) @(posedge clock);
        end
        repeat (4) @(posedge clock);
        check(tick_cnt, e);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) if (i != 1) rreg(i[2:0], 32'h0);
        rreg(ADR_NET_IRQ_IDENT, 32'h1);
        for (int i = 0; i < 4; i++) begin
            want[i] <= 1'b1;
            repeat (12) @(posedge clock);
            rreg(ADR_MODEM_STATUS, {want, (i == 2) ? 4'h0 : 4'h1 << i});
            rreg(ADR_MODEM_STATUS, {want, 4'h0});
        end
        want <= 4'h0;
        repeat (12) @(posedge clock);
        rreg(ADR_MODEM_STATUS, 32'h0F);
        wreg(ADR_MODEM_CONTROL, 32'h03);
        #1 check({rts_n, dtr_n, aux1_n, aux2_n}, 4'h3);
        rreg(ADR_MODEM_CONTROL, 32'h03);
        wreg(ADR_MODEM_CONTROL, 32'h1F);
        repeat (8) @(posedge clock);
        #1 check({pin_o, loop_on, rts_n}, 3'h6);
        rreg(ADR_MODEM_STATUS, 32'hFB);
        wreg(ADR_MODEM_CONTROL, 32'h10);
        repeat (8) @(posedge clock);
        rreg(ADR_MODEM_STATUS, 32'h0F);
        wreg(ADR_MODEM_CONTROL, 32'h00);
        repeat (8) @(posedge clock);
        rreg(ADR_MODEM_STATUS, 32'h00);
        // Network mode off: marker and match must stay quiet
        node = 8'($random(seed));
        wreg(ADR_NODE_ADDRESS, {24'h0, node});
        wreg(ADR_SCRATCH_STORE, 32'h01);
        #1 check({tx_marker, parity_en}, 2'h1);
        rx(node);
        rreg(ADR_NET_IRQ_IDENT, 32'h1);
        wreg(ADR_NETWORK_ENABLE, 32'hB4);
        #1 check({parity_en, tx_marker, nbr, nbt, pin_oe}, 5'h0D);
        rx(node ^ 8'h01);
        rreg(ADR_NET_IRQ_IDENT, 32'h1);
        rx(node);
        check(net_irq, 1'b1);
        rreg(ADR_NET_IRQ_IDENT, 32'hC);
        rx_read <= 1'b1;
        @(posedge clock);
        rx_read <= 1'b0;
        repeat (2) @(posedge clock);
        check(net_irq, 1'b0);
        rreg(ADR_NET_IRQ_IDENT, 32'h1);
        wreg(ADR_SCRATCH_STORE, 32'h00);
        #1 check(tx_marker, 1'b0);
        wreg(ADR_NETWORK_ENABLE, 32'h81);
        #1 check({tx_marker, pin_oe}, 2'h2);
        tx_empty <= 1'b0;
        tx_write <= 1'b1;
        @(posedge clock);
        tx_write <= 1'b0;
        @(posedge clock);
        tx_empty <= 1'b1;
        repeat (2) @(posedge clock);
        rreg(ADR_NET_IRQ_IDENT, 32'hA);
        iid_read <= 1'b1;
        @(posedge clock);
        iid_read <= 1'b0;
        rreg(ADR_NET_IRQ_IDENT, 32'h1);
        wreg(ADR_NETWORK_ENABLE, 32'hC0);
        #1 check({nbt, nbd}, 2'h2);
        wreg(ADR_NETWORK_ENABLE, 32'h88);
        #1 check({nbt, nbd, nbr}, 3'h2);
        wreg(ADR_NETWORK_ENABLE, 32'h84);
        repeat (8) begin
            @(posedge clock);
            tx_serial <= 1'($random(seed));
            @(posedge clock);
            #1 check({pin_oe, pin_o}, {1'b1, tx_serial});
        end
        // Fractional baud: bypass, M field zero means 4, M of 2
        ticks(16, 16);
        wreg(ADR_FRAC_DIVIDER, 32'h8000);
        ticks(16, 4);
        wreg(ADR_FRAC_DIVIDER, 32'h9000);
        ticks(16, 8);
        w1 = $random(seed);
        w2 = $random(seed);
        bus(1'b1, ADR_FRAC_DIVIDER, w1, 4'hF);
        bus(1'b1, ADR_FRAC_DIVIDER, w2, 4'h1);
        rreg(ADR_FRAC_DIVIDER, {16'h0, w1[15:8], w2[7:0]} & {16'h0, FD_MASK});
        wreg(3'h7, 32'hFF);
        rreg(3'h7, 32'h0);
        print_verdict();
    end
endmodule
